// file: rcps_refclk_power.v
/*
 * reference clock output divider and sleep/idle power-save sequencer.
 * assumes an APB master on CLK, a primary oscillator presented as a
 * synchronous level input, and a core that pulses the power-save request.
 */
`timescale 1ns/1ps
`include "rcps_regs.vh"
module rcps_refclk_power #(
	parameter DIV_W = 16
) (
	CLK,
	RESET_N,
	PSEL,
	PENABLE,
	PWRITE,
	PADDR,
	PWDATA,
	PRDATA,
	PREADY,
	PSLVERR,
	PRIMARY_OSC_IN,
	PS_REQ,
	PS_MODE,
	IRQ_PENDING,
	WDT_TIMEOUT,
	REFCLK_PIN,
	REFCLK_PIN_OE,
	HALF_RATE_CLOCK_PIN,
	CPU_CLK_EN,
	SYS_CLK_EN,
	PERIPH_CLK_EN,
	PRIMARY_OSC_EN,
	LOW_POWER_RC_EN,
	FAILSAFE_MON_EN,
	WATCHDOG_CLEAR,
	WAKE_PULSE,
	USB_CLK_OK
);
	input wire CLK;
	input wire RESET_N;
	input wire PSEL;
	input wire PENABLE;
	input wire PWRITE;
	input wire [11:0] PADDR;
	input wire [31:0] PWDATA;
	output reg [31:0] PRDATA;
	output reg PREADY;
	output reg PSLVERR;
	input wire PRIMARY_OSC_IN;
	input wire PS_REQ;
	input wire [7:0] PS_MODE;
	input wire IRQ_PENDING;
	input wire WDT_TIMEOUT;
	output reg REFCLK_PIN;
	output reg REFCLK_PIN_OE;
	output reg HALF_RATE_CLOCK_PIN;
	output reg CPU_CLK_EN;
	output reg SYS_CLK_EN;
	output reg PERIPH_CLK_EN;
	output reg PRIMARY_OSC_EN;
	output reg LOW_POWER_RC_EN;
	output reg FAILSAFE_MON_EN;
	output reg WATCHDOG_CLEAR;
	output reg WAKE_PULSE;
	output reg USB_CLK_OK;

	localparam [1:0] ST_RUN = 2'd0;
	localparam [1:0] ST_IDLE = 2'd1;
	localparam [1:0] ST_SLEEP = 2'd2;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [15:0] refctl_q;
	reg [4:0] pwrctl_q;
	reg [1:0] state_q;
	reg [DIV_W-1:0] cnt_q;
	reg posc_prev_q;
	reg half_q;
	reg [1:0] rst_seen_q;
	reg defer_q;

	wire out_en = refctl_q[`RCPS_BIT_OUT_EN];
	wire slp_cont = refctl_q[`RCPS_BIT_SLP_CONT];
	wire src_sel = refctl_q[`RCPS_BIT_SRC_SEL];
	wire [3:0] div_code = refctl_q[`RCPS_DIV_HI:`RCPS_DIV_LO];
	wire posc_keep = pwrctl_q[`RCPS_BIT_POSC_KEEP];
	wire wdt_en = pwrctl_q[`RCPS_BIT_WDT_EN];
	wire failsafe_clock_monitor_en = pwrctl_q[`RCPS_BIT_FAILSAFE_CLOCK_MONITOR_EN];

	wire apb_acc = PSEL && PENABLE;
	wire apb_wr = apb_acc && PWRITE;
	wire sleeping = (state_q == ST_SLEEP);
	wire posc_run = !sleeping || posc_keep;
	// the primary oscillator is the only base alive in sleep
	wire ref_run = !sleeping || (slp_cont && src_sel && posc_run);

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	function known_addr;
		input [11:0] a;
		begin
			known_addr = (a == `RCPS_ADDR_REFCTL) || (a == `RCPS_ADDR_PWRCTL) ||
				(a == `RCPS_ADDR_STATUS);
		end
	endfunction

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			refctl_q <= `RCPS_REFCTL_RESET;
			pwrctl_q <= 5'h00;
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !known_addr(PADDR);
			if (apb_wr && PADDR == `RCPS_ADDR_REFCTL) begin
				refctl_q <= PWDATA[15:0] & `RCPS_REFCTL_WMASK;
			end else if (apb_wr && PADDR == `RCPS_ADDR_PWRCTL) begin
				pwrctl_q <= PWDATA[4:0];
			end
			if (PSEL && !PENABLE && !PWRITE) begin
				if (PADDR == `RCPS_ADDR_REFCTL) begin
					PRDATA <= {16'h0000, refctl_q};
				end else if (PADDR == `RCPS_ADDR_PWRCTL) begin
					PRDATA <= {27'h000_0000, pwrctl_q};
				end else if (PADDR == `RCPS_ADDR_STATUS) begin
					PRDATA <= {30'h0000_0000, state_q};
				end else begin
					PRDATA <= 32'h0000_0000;
				end
			end
		end
	end

	// ----------------------------------------
	// power-save sequencer
	// ----------------------------------------
	// reset itself is a wake source: any reset returns to run
	wire wake = IRQ_PENDING || WDT_TIMEOUT || defer_q;

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= ST_RUN;
			WATCHDOG_CLEAR <= 1'b0;
			WAKE_PULSE <= 1'b0;
			defer_q <= 1'b0;
		end else begin
			WATCHDOG_CLEAR <= 1'b0;
			WAKE_PULSE <= 1'b0;
			case (state_q)
				ST_RUN: begin
					// interrupt seen with the request wakes right after entry
					defer_q <= PS_REQ && IRQ_PENDING &&
						(PS_MODE == `RCPS_PS_SLEEP || PS_MODE == `RCPS_PS_IDLE);
					// an interrupt pending now is held until entry is complete
					if (PS_REQ && PS_MODE == `RCPS_PS_SLEEP) begin
						state_q <= ST_SLEEP;
						WATCHDOG_CLEAR <= wdt_en;
					end else if (PS_REQ && PS_MODE == `RCPS_PS_IDLE) begin
						state_q <= ST_IDLE;
						WATCHDOG_CLEAR <= wdt_en;
					end
				end
				ST_IDLE, ST_SLEEP: begin
					if (wake) begin
						state_q <= ST_RUN;
						WAKE_PULSE <= 1'b1;
						defer_q <= 1'b0;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// clock gates follow state; the source choice is never touched so wake
	// resumes on the same clock
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CPU_CLK_EN <= 1'b1;
			SYS_CLK_EN <= 1'b1;
			PERIPH_CLK_EN <= 1'b1;
			PRIMARY_OSC_EN <= 1'b1;
			LOW_POWER_RC_EN <= 1'b0;
			FAILSAFE_MON_EN <= 1'b0;
			USB_CLK_OK <= 1'b0;
		end else begin
			CPU_CLK_EN <= (state_q == ST_RUN);
			SYS_CLK_EN <= !sleeping;
			PERIPH_CLK_EN <= !sleeping;
			PRIMARY_OSC_EN <= posc_run;
			LOW_POWER_RC_EN <= wdt_en || (!sleeping && failsafe_clock_monitor_en);
			FAILSAFE_MON_EN <= failsafe_clock_monitor_en && !sleeping;
			// fast rc with pll never qualifies for usb
			USB_CLK_OK <= pwrctl_q[`RCPS_BIT_PLL_MODE] && !pwrctl_q[`RCPS_BIT_FAST_RC_WITH_PLL_MODE];
		end
	end

	// ----------------------------------------
	// reference divider
	// ----------------------------------------
	// base tick: primary oscillator edge when selected, else every system clock
	// (so the output tracks any clock switch feeding CLK)
	wire posc_edge = PRIMARY_OSC_IN && !posc_prev_q;
	wire tick = src_sel ? posc_edge : 1'b1;
	// divide by 2^code: half period is 2^(code-1) ticks
	wire [DIV_W-1:0] half_period = ({{(DIV_W-1){1'b0}}, 1'b1} << div_code) >> 1;

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt_q <= {DIV_W{1'b0}};
			posc_prev_q <= 1'b0;
			REFCLK_PIN <= 1'b0;
			REFCLK_PIN_OE <= 1'b0;
			half_q <= 1'b0;
			HALF_RATE_CLOCK_PIN <= 1'b0;
			rst_seen_q <= 2'b00;
		end else begin
			posc_prev_q <= PRIMARY_OSC_IN;
			REFCLK_PIN_OE <= out_en;
			rst_seen_q <= {rst_seen_q[0], 1'b1};
			if (!out_en || !ref_run) begin
				cnt_q <= {DIV_W{1'b0}};
				REFCLK_PIN <= 1'b0;
			end else if (div_code == 4'h0) begin
				// code 0: oscillator passes through; a flop cannot pass CLK itself,
				// so the system-clock base gives CLK/2 at best
				if (src_sel) begin
					REFCLK_PIN <= PRIMARY_OSC_IN;
				end else begin
					REFCLK_PIN <= !REFCLK_PIN;
				end
			end else if (tick) begin
				if (cnt_q == half_period - {{(DIV_W-1){1'b0}}, 1'b1} ||
						cnt_q >= half_period) begin
					cnt_q <= {DIV_W{1'b0}};
					REFCLK_PIN <= !REFCLK_PIN;
				end else begin
					cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end
			if (SYS_CLK_EN) begin
				half_q <= !half_q;
			end
			HALF_RATE_CLOCK_PIN <= half_q;
		end
	end
endmodule

// file: rcps_regs.vh
/*
 * register map, field positions and reset values of the reference clock
 * output and power-save controller; assumes a 32-bit APB slave port.
 */
// What this block does
// - output enable bit 15 drives divided reference clock onto pin, else pin off
// - four-bit divisor at bits 11:8 picks one of 16 ratios; with source select clear codes 0 and 1 both give CLK/2
// - codes 1000..1111 divide by 256 up to 32768
// - source select bit 12: set primary oscillator, clear system clock
// - sleep-continue bit clear stops the reference output during sleep
// - output runs in sleep only with sleep-continue and source select set
// - with source select clear the output follows system clock switches
// - sleep powers down primary oscillator unless keep-enabled bit is set
// - sleep shuts down system clock source and halts code
// - idle halts the processor, system clock and peripherals keep running
// - wake from sleep or idle on enabled interrupt, reset or watchdog timeout
// - watchdog counter cleared just before sleep entry when enabled
// - low-power rc oscillator kept running in sleep when watchdog enabled
// - failsafe clock monitor inactive during sleep
// - system-clocked peripherals disabled in sleep; external-clocked ones may run
// - wake from sleep resumes on the clock source active at entry
// - idle entry clears watchdog; rc osc kept in idle if watchdog or monitor on
// - idle wake restores processor clock and resumes at once
// - interrupt during power-save instruction deferred until entry completes
// - usb possible only with primary oscillator plus pll system clock
// - half-rate clock pin at oscillator/2 in certain oscillator modes; here CLK/2 in every mode while SYS_CLK_EN is set
`ifndef RCPS_REGS_VH
`define RCPS_REGS_VH
`define RCPS_ADDR_REFCTL 12'h000
`define RCPS_ADDR_PWRCTL 12'h004
`define RCPS_ADDR_STATUS 12'h008
`define RCPS_REFCTL_WMASK 16'hBF00
`define RCPS_REFCTL_RESET 16'h0000
`define RCPS_BIT_OUT_EN 15
`define RCPS_BIT_SLP_CONT 13
`define RCPS_BIT_SRC_SEL 12
`define RCPS_DIV_HI 11
`define RCPS_DIV_LO 8
`define RCPS_BIT_POSC_KEEP 0
`define RCPS_BIT_WDT_EN 1
`define RCPS_BIT_FAILSAFE_CLOCK_MONITOR_EN 2
`define RCPS_BIT_PLL_MODE 3
`define RCPS_BIT_FAST_RC_WITH_PLL_MODE 4
`define RCPS_PS_IDLE 8'h01
`define RCPS_PS_SLEEP 8'h02
`endif

// file: rcps_refclk_monitor.sv
/* power-save and apb timing checker for rcps_refclk_power.
 * assumes one clock domain, bound by the statement at the foot. */
`timescale 1ns/1ps
module rcps_refclk_monitor (
	input wire CLK,
	input wire RESET_N,
	input wire PSEL,
	input wire PENABLE,
	input wire PREADY,
	input wire PSLVERR,
	input wire PS_REQ,
	input wire [7:0] PS_MODE,
	input wire IRQ_PENDING,
	input wire WDT_TIMEOUT,
	input wire HALF_RATE_CLOCK_PIN,
	input wire CPU_CLK_EN,
	input wire SYS_CLK_EN,
	input wire PERIPH_CLK_EN,
	input wire LOW_POWER_RC_EN,
	input wire FAILSAFE_MON_EN,
	input wire WATCHDOG_CLEAR,
	input wire WAKE_PULSE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_ps_irq;
		PS_REQ && CPU_CLK_EN && IRQ_PENDING && (PS_MODE == 8'h01 || PS_MODE == 8'h02);
	endsequence
	sequence s_halted_event;
		!CPU_CLK_EN && (IRQ_PENDING || WDT_TIMEOUT);
	endsequence
	chk_apb_answer: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no answer in access cycle");
	chk_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	chk_sleep_gates: assert property (!SYS_CLK_EN |-> !CPU_CLK_EN && !PERIPH_CLK_EN)
		else $error("clocks running in sleep");
	chk_mon_sleep: assert property (!SYS_CLK_EN |-> !FAILSAFE_MON_EN)
		else $error("monitor on in sleep");
	chk_idle_sys: assert property (CPU_CLK_EN |-> SYS_CLK_EN)
		else $error("cpu clock without system clock");
	chk_wdt_entry: assert property (WATCHDOG_CLEAR |=> !CPU_CLK_EN && !WATCHDOG_CLEAR)
		else $error("watchdog clear off entry");
	chk_rc_kept: assert property (WATCHDOG_CLEAR |-> LOW_POWER_RC_EN)
		else $error("rc oscillator off with watchdog");
	chk_wake_event: assert property (s_halted_event |-> ##[0:4] CPU_CLK_EN)
		else $error("no wake on event");
	chk_defer_wake: assert property (s_ps_irq |-> ##[1:6] WAKE_PULSE)
		else $error("deferred interrupt lost");
	chk_half_rate: assert property (SYS_CLK_EN [*6] |->
		HALF_RATE_CLOCK_PIN != $past(HALF_RATE_CLOCK_PIN))
		else $error("half rate pin wrong");
endmodule
bind rcps_refclk_power rcps_refclk_monitor rcps_refclk_monitor_inst (.*);

// file: rcps_board_model.sv
/* board model: primary oscillator and a load on the reference pin.
 * assumes sampling on the device clock. */
`timescale 1ns/1ps
module rcps_board_model (
	input wire logic clk,
	input wire logic osc_en,
	input wire logic pin,
	input wire logic oe,
	output logic osc,
	output int edges
);
	logic [1:0] div_q = 0;
	initial osc = 0;
	initial edges = 0;
	// oscillator stands still while powered down, so a stopped output is visible
	always @(posedge clk) if (osc_en) begin
		div_q <= div_q + 1;
		if (&div_q) osc <= ~osc;
	end
	always @(posedge pin) if (oe) edges <= edges + 1;
endmodule

// file: rcps_refclk_power_tb.sv
/* self-checking bench for rcps_refclk_power.
 * assumes the board model and the bound checker. */
`timescale 1ns/1ps
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module rcps_refclk_power_tb;
	logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PS_REQ = 0;
	logic IRQ_PENDING = 0, WDT_TIMEOUT = 0;
	logic [11:0] PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA, rd;
	logic [7:0] PS_MODE = 0;
	logic PREADY, PSLVERR, PRIMARY_OSC_IN, REFCLK_PIN, REFCLK_PIN_OE, HALF_RATE_CLOCK_PIN;
	logic CPU_CLK_EN, SYS_CLK_EN, PERIPH_CLK_EN, PRIMARY_OSC_EN, LOW_POWER_RC_EN;
	logic FAILSAFE_MON_EN, WATCHDOG_CLEAR, WAKE_PULSE, USB_CLK_OK, er;
	int fail_count = 0, checks_done = 0, edges, e0, p, i, wcs = 0, wks = 0, w0, k0;
	time t;
	rcps_refclk_power rcps_refclk_power_inst (.*);
	rcps_board_model rcps_board_model_inst (.clk(CLK), .osc_en(PRIMARY_OSC_EN),
		.pin(REFCLK_PIN), .oe(REFCLK_PIN_OE), .osc(PRIMARY_OSC_IN), .edges(edges));
	initial forever #12.5 CLK = ~CLK;
	always @(posedge CLK) begin
		wcs <= wcs + WATCHDOG_CLEAR;
		wks <= wks + WAKE_PULSE;
	end
	// ----
	// tasks
	// ----
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask
	task ps(input logic [7:0] m);
		w0 = wcs;
		@(posedge CLK);
		PS_REQ <= 1;
		PS_MODE <= m;
		@(posedge CLK);
		PS_REQ <= 0;
		repeat (4) @(posedge CLK);
		#1;
		`CK("wdt clear", w0 + 1, wcs)
	endtask
	task wake(input logic w);
		@(posedge CLK);
		IRQ_PENDING <= !w;
		WDT_TIMEOUT <= w;
		repeat (4) @(posedge CLK);
		IRQ_PENDING <= 0;
		WDT_TIMEOUT <= 0;
		@(posedge CLK);
		#1;
		`CK("awake", 1'b1, CPU_CLK_EN)
	endtask
	task per();
		@(posedge REFCLK_PIN);
		@(posedge REFCLK_PIN);
		t = $time;
		@(posedge REFCLK_PIN);
		p = ($time - t) / 25;
	endtask
	task cnt();
		e0 = edges;
		repeat (300) @(posedge CLK);
		p = edges - e0;
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#(25 * 60000);
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge CLK);
		RESET_N <= 1;
		xf(0, 12'h000, 0);
		`CK("refctl reset", 32'h0000_0000, rd)
		xf(1, 12'h000, 32'hFFFF_FFFF);
		xf(0, 12'h000, 0);
		`CK("refctl bits", 32'h0000_BF00, rd)
		xf(0, 12'h00C, 0);
		`CK("unmapped", 1'b1, er)
		$display("regs done");
		for (i = 0; i < 9; i += (i < 3) ? 1 : 5) begin
			xf(1, 12'h000, 32'h0000_8000 | (i << 8));
			per();
			`CK("div period", (i == 0) ? 2 : 2 ** i, p)
			`CK("oe on", 1'b1, REFCLK_PIN_OE)
		end
		xf(1, 12'h000, 0);
		cnt();
		`CK("off edges", 0, p)
		`CK("oe off", 1'b0, REFCLK_PIN_OE)
		xf(1, 12'h000, 32'h0000_9000);
		per();
		`CK("osc period", 8, p)
		$display("refclk done");
		xf(1, 12'h004, 32'h0000_0002);
		xf(1, 12'h000, 32'h0000_B000);
		ps(8'h02);
		`CK("sys off", 1'b0, SYS_CLK_EN)
		`CK("periph off", 1'b0, PERIPH_CLK_EN)
		`CK("posc off", 1'b0, PRIMARY_OSC_EN)
		`CK("rc kept", 1'b1, LOW_POWER_RC_EN)
		cnt();
		`CK("stopped", 0, p)
		wake(0);
		xf(1, 12'h004, 32'h0000_0007);
		repeat (2) @(posedge CLK);
		#1;
		`CK("mon on", 1'b1, FAILSAFE_MON_EN)
		ps(8'h02);
		`CK("mon off", 1'b0, FAILSAFE_MON_EN)
		`CK("posc kept", 1'b1, PRIMARY_OSC_EN)
		cnt();
		`CK("runs asleep", 1'b1, p > 0)
		wake(1);
		xf(1, 12'h000, 32'h0000_9000);
		ps(8'h02);
		cnt();
		`CK("stop asleep", 0, p)
		wake(0);
		$display("sleep done");
		ps(8'h01);
		`CK("cpu idle", 1'b0, CPU_CLK_EN)
		`CK("sys idle", 1'b1, SYS_CLK_EN)
		`CK("periph idle", 1'b1, PERIPH_CLK_EN)
		`CK("rc idle", 1'b1, LOW_POWER_RC_EN)
		wake(1);
		k0 = wks;
		@(posedge CLK);
		PS_REQ <= 1;
		PS_MODE <= 8'h01;
		IRQ_PENDING <= 1;
		@(posedge CLK);
		PS_REQ <= 0;
		IRQ_PENDING <= 0;
		repeat (6) @(posedge CLK);
		#1;
		`CK("deferred wake", k0 + 1, wks)
		`CK("deferred run", 1'b1, CPU_CLK_EN)
		$display("idle done");
		xf(1, 12'h004, 32'h0000_0008);
		repeat (2) @(posedge CLK);
		#1;
		`CK("usb ok", 1'b1, USB_CLK_OK)
		xf(1, 12'h004, 32'h0000_0018);
		repeat (2) @(posedge CLK);
		#1;
		`CK("usb frc", 1'b0, USB_CLK_OK)
		er = HALF_RATE_CLOCK_PIN;
		@(posedge CLK);
		#1;
		`CK("half rate", !er, HALF_RATE_CLOCK_PIN)
		$display("usb done");
		give_verdict();
	end
endmodule
